// [logic/sce_defs.svh]
`ifndef SCE_DEFS_SVH
`define SCE_DEFS_SVH

// Opcode patterns of the 14-bit instruction word.
`define SCE_OP_NOP 14'h0000
`define SCE_OP_WATCHDOG_CLEAR_OP 14'h0064
`define SCE_OP_CLRACC 14'h0100
`define SCE_OP_CLRACC_MASK 14'h3F80
`define SCE_OP_CLEAR_FILE_OP 14'h0180
`define SCE_OP_CLEAR_FILE_OP_MASK 14'h3F80
`define SCE_OP_DECREMENT_FILE_OP 14'h0300
`define SCE_OP_COMPLEMENT_FILE_OP 14'h0900
`define SCE_OP_BYTE_MASK 14'h3F00
`define SCE_OP_BTSS 14'h1C00
`define SCE_OP_BIT_MASK 14'h3C00
`define SCE_OP_CALL 14'h2000
`define SCE_OP_CALL_MASK 14'h3800

// Field positions.
`define SCE_F_ADDR_LSB 0
`define SCE_F_DEST_BIT 7
`define SCE_F_BIT_LSB 7
`define SCE_PCL_HI_LSB 3

// Reset and clear values.
`define SCE_ACC_RST 8'h00
`define SCE_PC_RST 13'h0000
`define SCE_WDT_CLR 8'h00
`define SCE_PRESC_CLR 8'h00
`define SCE_ZERO_BYTE 8'h00

`endif

// [logic/sce_pkg.sv]
package sce_pkg;
  // Decoded operation classes.
  typedef enum logic [3:0] {
    SCE_K_NOP, SCE_K_SKIPSET, SCE_K_WDCLR, SCE_K_CALL,
    SCE_K_COMPLEMENT_FILE_OP, SCE_K_CLEAR_FILE_OP, SCE_K_DECREMENT_FILE_OP, SCE_K_CLRACC
  } sce_kind_t;

  // Execution phase.
  typedef enum logic {SCE_S_EXEC, SCE_S_FLUSH} sce_state_t;
endpackage

// [logic/sce_dec_if.sv]
`timescale 1ns/1ps
// Decoded instruction fields shared between decoder and executor.
interface sce_dec_if;
  import sce_pkg::*;
  sce_kind_t kind;
  logic [6:0] faddr;
  logic [2:0] bsel;
  logic dest;
  logic [10:0] target;
  modport dec (output kind, faddr, bsel, dest, target);
  modport exe (input kind, faddr, bsel, dest, target);
endinterface

// [logic/sce_decoder.sv]
`timescale 1ns/1ps
`include "sce_defs.svh"
// Splits the instruction word into an operation class and operand fields.
module sce_decoder
  import sce_pkg::*;
(
  // Instruction word.
  input wire logic [13:0] instr,
  // Decoded fields.
  sce_dec_if.dec d
);
  // Classify the opcode; unknown words act as no-operation.
  always_comb
  begin
    d.kind = SCE_K_NOP;
    if (instr == `SCE_OP_WATCHDOG_CLEAR_OP)
      d.kind = SCE_K_WDCLR;
    else if ((instr & `SCE_OP_CLRACC_MASK) == `SCE_OP_CLRACC)
      d.kind = SCE_K_CLRACC;
    else if ((instr & `SCE_OP_CLEAR_FILE_OP_MASK) == `SCE_OP_CLEAR_FILE_OP)
      d.kind = SCE_K_CLEAR_FILE_OP;
    else if ((instr & `SCE_OP_BYTE_MASK) == `SCE_OP_DECREMENT_FILE_OP)
      d.kind = SCE_K_DECREMENT_FILE_OP;
    else if ((instr & `SCE_OP_BYTE_MASK) == `SCE_OP_COMPLEMENT_FILE_OP)
      d.kind = SCE_K_COMPLEMENT_FILE_OP;
    else if ((instr & `SCE_OP_BIT_MASK) == `SCE_OP_BTSS)
      d.kind = SCE_K_SKIPSET;
    else if ((instr & `SCE_OP_CALL_MASK) == `SCE_OP_CALL)
      d.kind = SCE_K_CALL;
  end

  // Operand fields.
  assign d.faddr = instr[`SCE_F_ADDR_LSB +: 7];
  assign d.bsel = instr[`SCE_F_BIT_LSB +: 3];
  assign d.dest = instr[`SCE_F_DEST_BIT];
  assign d.target = instr[10:0];
endmodule // sce_decoder

// [logic/sce_file_alu.sv]
`timescale 1ns/1ps
// Byte operations on a file register value and the resulting zero flag.
module sce_file_alu
  import sce_pkg::*;
(
  // Operation and operand.
  input wire sce_kind_t kind,
  input wire logic [7:0] fval,
  // Result.
  output logic [7:0] res,
  output logic zero
);
  // Compute complement, decrement or clear.
  always_comb
  begin
    unique case (kind)
      SCE_K_COMPLEMENT_FILE_OP: res = ~fval;
      SCE_K_DECREMENT_FILE_OP: res = fval - 8'h01;
      default: res = 8'h00;
    endcase
  end

  // Zero flag follows the byte result whatever the destination.
  assign zero = (res == 8'h00);
endmodule // sce_file_alu

// [logic/sce_core.sv]
`timescale 1ns/1ps
`include "sce_defs.svh"
//
// Overview of operation
// - Skip-if-set runs next instruction when bit zero.
// - Bit set: next flushed as no-op, flags kept.
// - Watchdog clear zeroes counter and prescaler.
// - Watchdog clear sets both active-low status flags.
// - Call pushes program counter plus one.
// - Call loads eleven-bit target into low bits.
// - Call copies latch bits 4:3 to bits 12:11.
// - Call takes two cycles, flags unchanged.
// - Complement inverts register, destination bit selects.
// - Clear-file writes zero and sets zero flag.
// - Decrement subtracts one, updates only zero flag.
// - Destination one writes back to file register.
// - Clear-accumulator zeroes accumulator, sets zero flag.
// - Second cycle of two-cycle instructions is no-op.
//
module sce_core
  import sce_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int WDT_W = 8,
  parameter int PRESC_W = 8
)
(
  // Clock, reset and enable.
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  // Fetched instruction and its address.
  input wire logic [13:0] INSTR,
  input wire logic [PC_W-1:0] PC_IN,
  input wire logic [7:0] PC_HIGH_LATCH,
  // File register read data for the addressed register.
  input wire logic [7:0] FILE_RDATA,
  // Present status flags.
  input wire logic ZERO_IN,
  // File register access.
  output logic [6:0] FILE_ADDR,
  output logic [7:0] FILE_WDATA,
  output logic FILE_WE,
  // Accumulator.
  output logic [7:0] ACC,
  // Status flag updates.
  output logic ZERO_OUT,
  output logic ZERO_WE,
  output logic WATCHDOG_EXPIRED_N,
  output logic POWERDOWN_FLAG_N,
  output logic STATUS_N_WE,
  // Return stack push.
  output logic [PC_W-1:0] STACK_TOP,
  output logic STACK_PUSH,
  // Program counter load.
  output logic [PC_W-1:0] PC_OUT,
  output logic PC_LOAD,
  // Watchdog clear.
  output logic [WDT_W-1:0] WATCHDOG_COUNTER,
  output logic [PRESC_W-1:0] WATCHDOG_PRESCALER,
  output logic WATCHDOG_CLEAR,
  // Cycle status.
  output logic FLUSH_CYCLE
);
  // Refuse widths that the call and watchdog logic cannot serve.
  // The call target is a two-bit latch field above an eleven-bit operand.
  if (PC_W != 13)
  begin : g_pc_w_chk
    $error("PC_W must be 13");
  end
  // The watchdog clear values need at least one bit to land in.
  if (WDT_W < 1)
  begin : g_wdt_w_chk
    $error("WDT_W must be positive");
  end
  // The prescaler clear value needs at least one bit as well.
  if (PRESC_W < 1)
  begin : g_presc_w_chk
    $error("PRESC_W must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding and byte operations.

  sce_dec_if dec_b ();
  logic [7:0] alu_res;
  logic alu_zero;
  sce_state_t state_r;
  logic exec;
  logic bit_set;

  sce_decoder u_dec (
    .instr(INSTR),
    .d(dec_b.dec)
  );

  sce_file_alu u_alu (
    .kind(dec_b.kind),
    .fval(FILE_RDATA),
    .res(alu_res),
    .zero(alu_zero)
  );

  // The register file answers combinationally to the address in the word.
  // The tested bit is therefore valid in the same cycle as the word.
  // A word that decodes to nothing known behaves as a no-operation.
  // An instruction executes only outside a flush cycle.
  assign exec = CE && (state_r == SCE_S_EXEC);
  assign bit_set = FILE_RDATA[dec_b.bsel];

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing.

  // The flush cycle throws away a word that was already fetched.
  // Program counter sequencing lives outside, so only the discard is done here.
  // A low enable freezes the phase, so a pending flush waits for it.
  // Skips taken and calls enter a flush cycle; everything else stays single.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      state_r <= SCE_S_EXEC;
    else if (CE)
    begin
      unique case (state_r)
        SCE_S_EXEC:
          if (dec_b.kind == SCE_K_CALL)
            state_r <= SCE_S_FLUSH;
          else if (dec_b.kind == SCE_K_SKIPSET && bit_set)
            state_r <= SCE_S_FLUSH;
          else
            state_r <= SCE_S_EXEC;
        SCE_S_FLUSH:
          state_r <= SCE_S_EXEC;
      endcase
    end
  end

  // Marks the discarded second cycle.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      FLUSH_CYCLE <= 1'b0;
    else if (CE)
      FLUSH_CYCLE <= (state_r == SCE_S_EXEC) && ((dec_b.kind == SCE_K_CALL)
        || (dec_b.kind == SCE_K_SKIPSET && bit_set));
  end

  ////////////////////////////////////////////////////////////////////////////
  // File register write-back and accumulator.

  // Address and data follow every word, but only the strobe commits them.
  // The partner must therefore write only while the strobe is high.
  // Results go to the file register or the accumulator by destination bit.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      FILE_ADDR <= 7'h00;
      FILE_WDATA <= `SCE_ZERO_BYTE;
      FILE_WE <= 1'b0;
    end
    else if (CE)
    begin
      FILE_ADDR <= dec_b.faddr;
      FILE_WDATA <= alu_res;
      FILE_WE <= 1'b0;
      if (exec)
      begin
        if (dec_b.kind == SCE_K_CLEAR_FILE_OP)
          FILE_WE <= 1'b1;
        else if ((dec_b.kind == SCE_K_COMPLEMENT_FILE_OP || dec_b.kind == SCE_K_DECREMENT_FILE_OP) && dec_b.dest)
          FILE_WE <= 1'b1;
      end
    end
  end

  // Accumulator loads results with destination zero, or is cleared.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      ACC <= `SCE_ACC_RST;
    else if (exec)
    begin
      if (dec_b.kind == SCE_K_CLRACC)
        ACC <= `SCE_ZERO_BYTE;
      else if ((dec_b.kind == SCE_K_COMPLEMENT_FILE_OP || dec_b.kind == SCE_K_DECREMENT_FILE_OP) && !dec_b.dest)
        ACC <= alu_res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.

  // When no write is due the present flag is passed through unchanged.
  // This keeps the flag port meaningful even if a user ignores the strobe.
  // Zero flag is written only by the byte operations and the clears.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ZERO_OUT <= 1'b0;
      ZERO_WE <= 1'b0;
    end
    else if (CE)
    begin
      ZERO_OUT <= ZERO_IN;
      ZERO_WE <= 1'b0;
      if (exec)
      begin
        unique case (dec_b.kind)
          SCE_K_CLEAR_FILE_OP, SCE_K_CLRACC:
          begin
            ZERO_OUT <= 1'b1;
            ZERO_WE <= 1'b1;
          end
          SCE_K_COMPLEMENT_FILE_OP, SCE_K_DECREMENT_FILE_OP:
          begin
            ZERO_OUT <= alu_zero;
            ZERO_WE <= 1'b1;
          end
          default:
            ZERO_WE <= 1'b0;
        endcase
      end
    end
  end

  // Watchdog clear raises both active-low status flags.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      WATCHDOG_EXPIRED_N <= 1'b1;
      POWERDOWN_FLAG_N <= 1'b1;
      STATUS_N_WE <= 1'b0;
    end
    else if (CE)
    begin
      STATUS_N_WE <= exec && (dec_b.kind == SCE_K_WDCLR);
      WATCHDOG_EXPIRED_N <= 1'b1;
      POWERDOWN_FLAG_N <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog clear.

  // The time-out logic itself sits outside and reacts to the strobe.
  // The value ports are constant so that they can be wired straight to a load.
  // Counter and prescaler are loaded with zero by the clear strobe.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      WATCHDOG_CLEAR <= 1'b0;
      WATCHDOG_COUNTER <= '0;
      WATCHDOG_PRESCALER <= '0;
    end
    else if (CE)
    begin
      WATCHDOG_CLEAR <= exec && (dec_b.kind == SCE_K_WDCLR);
      WATCHDOG_COUNTER <= WDT_W'(`SCE_WDT_CLR);
      WATCHDOG_PRESCALER <= PRESC_W'(`SCE_PRESC_CLR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Call: stack push and program counter load.

  // The return address is taken from the address of the call word itself.
  // Only two latch bits reach the target; the others are ignored on purpose.
  // Push and load strobe together, so the stack sees the old counter value.
  // Return address is pushed in the same cycle that the new target is loaded.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      STACK_TOP <= `SCE_PC_RST;
      STACK_PUSH <= 1'b0;
      PC_OUT <= `SCE_PC_RST;
      PC_LOAD <= 1'b0;
    end
    else if (CE)
    begin
      STACK_PUSH <= 1'b0;
      PC_LOAD <= 1'b0;
      if (exec && dec_b.kind == SCE_K_CALL)
      begin
        STACK_TOP <= PC_W'(PC_IN + 1'b1);
        STACK_PUSH <= 1'b1;
        PC_OUT <= {PC_HIGH_LATCH[`SCE_PCL_HI_LSB +: 2], dec_b.target};
        PC_LOAD <= 1'b1;
      end
    end
  end
endmodule // sce_core

// [verification/sce_core_sva.sv]
`timescale 1ns/1ps
////////////////////////////////////////
// Port-level checks of the execution core.
module sce_core_chk
#(
  parameter int PC_W = 13,
  parameter int WDT_W = 8,
  parameter int PRESC_W = 8
)
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Instruction side.
  input wire logic CE,
  input wire logic [13:0] INSTR,
  input wire logic [PC_W-1:0] PC_IN,
  input wire logic [7:0] PC_HIGH_LATCH,
  input wire logic [7:0] FILE_RDATA,
  // Results.
  input wire logic [6:0] FILE_ADDR,
  input wire logic [7:0] FILE_WDATA,
  input wire logic FILE_WE,
  input wire logic [7:0] ACC,
  input wire logic ZERO_OUT,
  input wire logic ZERO_WE,
  input wire logic WATCHDOG_EXPIRED_N,
  input wire logic POWERDOWN_FLAG_N,
  input wire logic STATUS_N_WE,
  input wire logic [PC_W-1:0] STACK_TOP,
  input wire logic STACK_PUSH,
  input wire logic [PC_W-1:0] PC_OUT,
  input wire logic PC_LOAD,
  input wire logic [WDT_W-1:0] WATCHDOG_COUNTER,
  input wire logic [PRESC_W-1:0] WATCHDOG_PRESCALER,
  input wire logic WATCHDOG_CLEAR,
  input wire logic FLUSH_CYCLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // A word is taken when enabled outside a flush; hit marks a set tested bit.
  wire take = CE && !FLUSH_CYCLE;
  wire hit = INSTR[13:10] == 4'h7 && FILE_RDATA[INSTR[9:7]];
  // Steps of the two-cycle behaviours.
  sequence call_s;
    take && INSTR[13:11] == 3'h4;
  endsequence
  sequence skip_s;
    take && hit;
  endsequence
  sequence flush_s;
    FLUSH_CYCLE && CE;
  endsequence
  call_push_a: assert property (call_s |=> STACK_PUSH && STACK_TOP == $past(PC_IN) + 1'b1)
    else $error("call return address wrong");
  call_target_a: assert property (call_s |=> PC_LOAD && FLUSH_CYCLE && !ZERO_WE &&
    PC_OUT == {$past(PC_HIGH_LATCH[4:3]), $past(INSTR[10:0])})
    else $error("call target wrong");
  flush_noop_a: assert property (flush_s |=> !(PC_LOAD || STACK_PUSH || FILE_WE || ZERO_WE))
    else $error("flushed word executed");
  one_cycle_a: assert property (take && INSTR[13:11] != 3'h4 && !hit |=> !FLUSH_CYCLE)
    else $error("unexpected flush");
  skip_set_a: assert property (skip_s |=> FLUSH_CYCLE && !ZERO_WE && !STATUS_N_WE)
    else $error("skip not taken");
  wdt_clear_a: assert property (take && INSTR == 14'h0064 |=> WATCHDOG_CLEAR && STATUS_N_WE &&
    WATCHDOG_EXPIRED_N && POWERDOWN_FLAG_N && WATCHDOG_COUNTER == '0 &&
    WATCHDOG_PRESCALER == '0 && !ZERO_WE)
    else $error("watchdog clear wrong");
  clear_file_op_zero_a: assert property (take && INSTR[13:7] == 7'h03 |=> FILE_WE &&
    FILE_WDATA == 8'h00 && FILE_ADDR == $past(INSTR[6:0]) && ZERO_WE && ZERO_OUT)
    else $error("clear file wrong");
  clracc_zero_a: assert property (take && INSTR[13:7] == 7'h02 |=> ACC == 8'h00 && ZERO_OUT)
    else $error("clear accumulator wrong");
  complement_file_op_zero_a: assert property (take && INSTR[13:8] == 6'h09 |=>
    ZERO_WE && ZERO_OUT == ($past(FILE_RDATA) == 8'hFF))
    else $error("complement zero flag wrong");
  decrement_file_op_back_a: assert property (take && INSTR[13:7] == 7'h07 |=>
    FILE_WE && FILE_WDATA == $past(FILE_RDATA) - 8'h01)
    else $error("decrement write back wrong");
endmodule // sce_core_chk

bind sce_core sce_core_chk #(.PC_W(PC_W), .WDT_W(WDT_W), .PRESC_W(PRESC_W)) u_chk (.*);

// [verification/sce_file_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////
// Data register file: read follows the address at once, writes land on the edge.
module sce_file_model
(
  // Clock.
  input wire logic clk,
  // Read port.
  input wire logic [6:0] raddr,
  output logic [7:0] rdata,
  // Write port.
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata
);
  logic [7:0] mem [0:127];
  // Combinational read of the addressed byte.
  assign rdata = mem[raddr];
  // Stores a written byte on the pulse.
  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end
endmodule // sce_file_model

// [verification/tb.sv]
`timescale 1ns/1ps
////////////////////////////////////////
// Self-checking bench of the execution core.
module tb;
  logic clk, rst, ce, zero_in, file_we, zero_out, zero_we, exp_n, pd_n, st_we, push, pc_load;
  logic wd_clr, flush;
  logic [13:0] instr;
  logic [12:0] pc_in, stack_top, pc_out;
  logic [7:0] latch, rdata, wdata, acc, wd_cnt, wd_pre;
  logic [6:0] faddr;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  sce_core u_dut (.CLK(clk), .SYS_RST(rst), .CE(ce), .INSTR(instr), .PC_IN(pc_in),
    .PC_HIGH_LATCH(latch), .FILE_RDATA(rdata), .ZERO_IN(zero_in), .FILE_ADDR(faddr),
    .FILE_WDATA(wdata), .FILE_WE(file_we), .ACC(acc), .ZERO_OUT(zero_out), .ZERO_WE(zero_we),
    .WATCHDOG_EXPIRED_N(exp_n), .POWERDOWN_FLAG_N(pd_n), .STATUS_N_WE(st_we),
    .STACK_TOP(stack_top), .STACK_PUSH(push), .PC_OUT(pc_out), .PC_LOAD(pc_load),
    .WATCHDOG_COUNTER(wd_cnt), .WATCHDOG_PRESCALER(wd_pre), .WATCHDOG_CLEAR(wd_clr),
    .FLUSH_CYCLE(flush));
  sce_file_model u_mem (.clk(clk), .raddr(instr[6:0]), .rdata(rdata), .we(file_we),
    .waddr(faddr), .wdata(wdata));
  // A 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Presents one word at a falling edge and returns once its results are settled.
  task automatic exec(input logic [13:0] w);
    instr = w;
    ce = 1'b1;
    @(negedge clk);
  endtask
  ////////////////////////////////////////
  // Decrement into the accumulator, then clear it.
  task automatic t_acc;
    u_mem.mem[7'h10] = 8'h00;
    exec(14'h0310);
    chk("decrement_file_op", {file_we, zero_we, zero_out, acc}, 16'h02FF);
    exec(14'h0100);
    chk("clear_accumulator_op", {zero_we, zero_out, acc}, 16'h0300);
  endtask
  // Results written back to the file, then a complement into the accumulator.
  task automatic t_wback;
    u_mem.mem[7'h11] = 8'hFF;
    u_mem.mem[7'h12] = 8'h00;
    exec(14'h0991);
    chk("complement_file_op f", {file_we, faddr, wdata}, 16'h9100);
    chk("complement_file_op z", {zero_we, zero_out}, 2'h3);
    exec(14'h0392);
    chk("decrement_file_op f", {file_we, faddr, wdata}, 16'h92FF);
    chk("decrement_file_op a", {zero_out, acc}, 9'h000);
    u_mem.mem[7'h13] = 8'h5A;
    exec(14'h0913);
    chk("complement_file_op w", {file_we, zero_out, acc}, 10'h0A5);
    chk("mem", {u_mem.mem[7'h11], u_mem.mem[7'h12]}, 16'h00FF);
  endtask
  // Clear of the highest file address.
  task automatic t_clear_file_op;
    u_mem.mem[7'h7F] = 8'h33;
    exec(14'h01FF);
    chk("clear_file_op", {file_we, faddr, wdata}, 16'hFF00);
    chk("clear_file_op z", {zero_we, zero_out}, 2'h3);
    exec(14'h0000);
    chk("clear_file_op m", u_mem.mem[7'h7F], 8'h00);
  endtask
  // Watchdog clear, first held back by the enable.
  task automatic t_wdt;
    instr = 14'h0064;
    ce = 1'b0;
    @(negedge clk);
    chk("wdt ce", wd_clr, 1'b0);
    zero_in = 1'b1;
    exec(14'h0064);
    chk("wdt", {wd_clr, st_we, exp_n, pd_n, zero_we, zero_out}, 6'h3D);
    chk("wdt v", {wd_cnt, wd_pre}, 16'h0000);
    zero_in = 1'b0;
  endtask
  // Call, then a word in the flush cycle that must be dropped.
  task automatic t_call;
    pc_in = 13'h0ABC;
    latch = 8'hF7;
    exec(14'h27FF);
    chk("call", {push, pc_load, flush, zero_we}, 4'hE);
    chk("call ret", stack_top, 13'h0ABD);
    chk("call pc", pc_out, 13'h17FF);
    exec(14'h0100);
    chk("call nop", {push, pc_load, flush, zero_we, acc}, 12'h0A5);
  endtask
  // Skip on every bit position, then a clear bit that runs the next word.
  task automatic t_skip;
    for (int b = 0; b < 8; b++)
    begin
      u_mem.mem[7'h05] = 8'h01 << b;
      exec(14'h1C05 | 14'(b << 7));
      chk("skip", {flush, zero_we}, 2'h2);
      exec(14'h0100);
      chk("skip nop", {flush, acc}, 9'h0A5);
    end
    u_mem.mem[7'h06] = 8'hFE;
    exec(14'h1C06);
    chk("noskip", flush, 1'b0);
    exec(14'h0100);
    chk("noskip w", acc, 8'h00);
  endtask
  ////////////////////////////////////////
  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      fails++;
      print_verdict;
    end
  end
  // Reset, then the scenarios in turn.
  initial
  begin
    rst = 1'b1;
    ce = 1'b0;
    instr = 14'h0000;
    pc_in = 13'h0000;
    latch = 8'h00;
    zero_in = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk("rst", {acc, push, pc_load, flush}, 11'h000);
    t_acc;
    t_wback;
    t_clear_file_op;
    t_wdt;
    t_call;
    t_skip;
    print_verdict;
  end
endmodule // tb
